// [pkg/psw_pkg.sv]
/*
  Constants, types and register map of the serial-port power-save and
  wake control block. Assumes a 125 MHz core clock and an APB master.
*/
// Notes on behaviour
// - DTR setting: port re-enabled 20 ms after DTR goes ON while idle.
// - RTS setting: port re-enabled 20 ms after RTS goes ON while idle.
// - after line wake-up every received character is accepted while active; the code holds characters off while the FIFO is full.
// - periodic setting: idle whenever possible, port enabled in periodic windows.
// - DTR setting is refused on the first product version.
// - CTS driven low when active, port enabled and flow control on.
// - flow control is on after reset; turning it off is explicit.
// - DTR setting accepted with flow control either on or off.
// - RTS setting accepted only while flow control is off.
// - line settings: port disabled at once when controlling line goes OFF.
package psw_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CHAR_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned TMR_W = 32;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IDLE = 8'h04;
  localparam logic [7:0] REG_ACT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RXDATA = 8'h10;

  // control word: power_save_select in the low bits, flow control above
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_FLOW_BIT = 4;
  localparam int unsigned STS_ACTIVE_BIT = 0;
  localparam int unsigned STS_PORT_BIT = 1;
  localparam int unsigned STS_CTS_BIT = 2;
  localparam int unsigned STS_REJ_BIT = 3;
  localparam int unsigned STS_EMPTY_BIT = 4;
  localparam int unsigned STS_FULL_BIT = 5;
  localparam int unsigned STS_WAKE_BIT = 6;
  localparam int unsigned RXD_VALID_BIT = 8;

  typedef enum logic [1:0] {PS_OFF, PS_PERIODIC, PS_RTS, PS_DTR} ps_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_ACTIVE} pwr_state_t;

  localparam ps_mode_t MODE_RST = PS_OFF;
  localparam logic FLOW_RST = 1'b1;
  localparam logic [TMR_W-1:0] IDLE_RST = 32'h0001_0000;
  localparam logic [TMR_W-1:0] ACT_RST = 32'h0000_4000;
  localparam logic [7:0] VER_FIRST = 8'h01;

  localparam longint unsigned WAKE_TIME_MS = 20;
  localparam longint unsigned CLK_HZ = 125_000_000;
  localparam longint unsigned MS_PER_S = 1000;
  // least time: rounded up to whole cycles
  localparam longint unsigned WAKE_CYC =
    (WAKE_TIME_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
endpackage

// [hw/char_fifo.sv]
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two; one clock, asynchronous reset.
*/
`timescale 1ns/1ps
module char_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic push;
  logic pop;

  assign out_valid = wr_ff != rd_ff;
  assign in_ready = (wr_ff[AW] == rd_ff[AW]) || (wr_ff[AW-1:0] != rd_ff[AW-1:0]);
  assign out_data = mem_ff[rd_ff[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule

// [hw/span_timer.sv]
/*
  Loadable down-counter; done is high in the cycle the count reaches zero.
  Assumes one clock and asynchronous reset.
*/
`timescale 1ns/1ps
module span_timer #(
  parameter int unsigned W = 32
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] cnt_ff;
  logic run_ff;

  assign done = run_ff && (cnt_ff == '0);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else if (load) begin
      cnt_ff <= load_val;
      run_ff <= 1'b1;
    end else if (done) begin
      run_ff <= 1'b0;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule

// [hw/uart_psave_ctrl.sv]
/*
  Power-save and wake control of the module serial port, with an APB
  register file and a receive FIFO. Assumes a character receiver that
  offers bytes by valid/ready, and RTS/DTR inputs synchronous to mclk.
*/
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module uart_psave_ctrl #(
  parameter logic [31:0] WAKE_CYCLES = 32'(psw_pkg::WAKE_CYC),
  parameter logic [7:0] PRODUCT_VER = 8'h02,
  parameter int unsigned FIFO_DEPTH = psw_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [psw_pkg::ADDR_W-1:0] paddr,
  input wire logic [psw_pkg::DATA_W-1:0] pwdata,
  output logic [psw_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rts_n,
  input wire logic dtr_n,
  output logic cts_n,
  output logic port_en,
  output logic mod_active,
  input wire logic rx_valid,
  input wire logic [psw_pkg::CHAR_W-1:0] rx_data,
  output logic rx_ready
);
  psw_pkg::ps_mode_t mode_ff;
  psw_pkg::pwr_state_t state_ff;
  psw_pkg::pwr_state_t nxt_state;
  logic flow_en_ff;
  logic [psw_pkg::TMR_W-1:0] idle_len_ff;
  logic [psw_pkg::TMR_W-1:0] act_len_ff;
  logic rej_ff;
  logic port_en_ff;
  logic cts_n_ff;
  logic [psw_pkg::DATA_W-1:0] prdata_ff;
  logic slverr_ff;

  logic setup;
  logic access;
  logic addr_ok;
  logic ctrl_wr;
  logic ctrl_bad;
  logic ctrl_ok;
  logic sts_wr;
  logic rxd_rd;
  psw_pkg::ps_mode_t wr_mode;
  logic wr_flow;
  logic line_on;
  logic tmr_load;
  logic [psw_pkg::TMR_W-1:0] tmr_val;
  logic tmr_done;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [psw_pkg::CHAR_W-1:0] fifo_out_data;
  logic rx_take;

  // apb decode
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = access;
  assign pslverr = access && slverr_ff;
  assign prdata = prdata_ff;
  assign wr_mode = psw_pkg::ps_mode_t'(pwdata[psw_pkg::CTRL_MODE_LSB +: 2]);
  assign wr_flow = pwdata[psw_pkg::CTRL_FLOW_BIT];

  always_comb begin
    case (paddr)
      psw_pkg::REG_CTRL,
      psw_pkg::REG_IDLE,
      psw_pkg::REG_ACT,
      psw_pkg::REG_STATUS,
      psw_pkg::REG_RXDATA: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // settings refused outright so a bad write cannot half-apply
  assign ctrl_bad = ((wr_mode == psw_pkg::PS_DTR) &&
                     (PRODUCT_VER == psw_pkg::VER_FIRST)) ||
                    ((wr_mode == psw_pkg::PS_RTS) && wr_flow);
  assign ctrl_wr = access && pwrite && (paddr == psw_pkg::REG_CTRL);
  assign ctrl_ok = ctrl_wr && !ctrl_bad;
  assign sts_wr = access && pwrite && (paddr == psw_pkg::REG_STATUS);
  assign rxd_rd = access && !pwrite && (paddr == psw_pkg::REG_RXDATA);

  // control registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= psw_pkg::MODE_RST;
      flow_en_ff <= psw_pkg::FLOW_RST;
    end else if (ctrl_ok) begin
      mode_ff <= wr_mode;
      flow_en_ff <= wr_flow;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idle_len_ff <= psw_pkg::IDLE_RST;
      act_len_ff <= psw_pkg::ACT_RST;
    end else if (access && pwrite) begin
      if (paddr == psw_pkg::REG_IDLE) begin
        idle_len_ff <= pwdata;
      end
      if (paddr == psw_pkg::REG_ACT) begin
        act_len_ff <= pwdata;
      end
    end
  end

  // sticky refusal flag, write one to clear; a new refusal wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rej_ff <= 1'b0;
    end else if (ctrl_wr && ctrl_bad) begin
      rej_ff <= 1'b1;
    end else if (sts_wr && pwdata[psw_pkg::STS_REJ_BIT]) begin
      rej_ff <= 1'b0;
    end
  end

  // read data captured in setup, so prdata comes from a flop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_ff <= '0;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= '0;
      slverr_ff <= !addr_ok ||
                   (pwrite && (paddr == psw_pkg::REG_CTRL) && ctrl_bad);
      if (!pwrite) begin
        case (paddr)
          psw_pkg::REG_CTRL: begin
            prdata_ff[psw_pkg::CTRL_MODE_LSB +: 2] <= mode_ff;
            prdata_ff[psw_pkg::CTRL_FLOW_BIT] <= flow_en_ff;
          end
          psw_pkg::REG_IDLE: prdata_ff <= idle_len_ff;
          psw_pkg::REG_ACT: prdata_ff <= act_len_ff;
          psw_pkg::REG_STATUS: begin
            prdata_ff[psw_pkg::STS_ACTIVE_BIT] <= state_ff == psw_pkg::ST_ACTIVE;
            prdata_ff[psw_pkg::STS_PORT_BIT] <= port_en_ff;
            prdata_ff[psw_pkg::STS_CTS_BIT] <= cts_n_ff;
            prdata_ff[psw_pkg::STS_REJ_BIT] <= rej_ff;
            prdata_ff[psw_pkg::STS_EMPTY_BIT] <= !fifo_out_valid;
            prdata_ff[psw_pkg::STS_FULL_BIT] <= !fifo_in_ready;
            prdata_ff[psw_pkg::STS_WAKE_BIT] <= state_ff == psw_pkg::ST_WAKE;
          end
          psw_pkg::REG_RXDATA: begin
            prdata_ff[psw_pkg::CHAR_W-1:0] <= fifo_out_data;
            prdata_ff[psw_pkg::RXD_VALID_BIT] <= fifo_out_valid;
          end
          default: prdata_ff <= '0;
        endcase
      end
    end
  end

  // power state
  assign line_on = (mode_ff == psw_pkg::PS_RTS) ? !rts_n : !dtr_n;
  assign rx_take = rx_valid && rx_ready;

  always_comb begin
    nxt_state = state_ff;
    tmr_load = 1'b0;
    tmr_val = act_len_ff;
    if (ctrl_ok) begin
      // a new periodic setting may go idle at once, no timeout wait
      if (wr_mode == psw_pkg::PS_PERIODIC) begin
        nxt_state = psw_pkg::ST_IDLE;
        tmr_load = 1'b1;
        tmr_val = idle_len_ff;
      end else begin
        nxt_state = psw_pkg::ST_ACTIVE;
      end
    end else begin
      case (mode_ff)
        psw_pkg::PS_OFF: nxt_state = psw_pkg::ST_ACTIVE;
        psw_pkg::PS_PERIODIC: begin
          case (state_ff)
            psw_pkg::ST_ACTIVE: begin
              if (rx_take) begin
                tmr_load = 1'b1;
              end else if (tmr_done) begin
                nxt_state = psw_pkg::ST_IDLE;
                tmr_load = 1'b1;
                tmr_val = idle_len_ff;
              end
            end
            psw_pkg::ST_IDLE: begin
              if (tmr_done) begin
                nxt_state = psw_pkg::ST_ACTIVE;
                tmr_load = 1'b1;
              end
            end
            default: begin
              nxt_state = psw_pkg::ST_ACTIVE;
              tmr_load = 1'b1;
            end
          endcase
        end
        default: begin
          if (!line_on) begin
            nxt_state = psw_pkg::ST_IDLE;
          end else begin
            case (state_ff)
              psw_pkg::ST_IDLE: begin
                nxt_state = psw_pkg::ST_WAKE;
                tmr_load = 1'b1;
                tmr_val = WAKE_CYCLES - 32'h0000_0001;
              end
              psw_pkg::ST_WAKE: begin
                if (tmr_done) begin
                  nxt_state = psw_pkg::ST_ACTIVE;
                end
              end
              default: nxt_state = psw_pkg::ST_ACTIVE;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= psw_pkg::ST_ACTIVE;
      port_en_ff <= 1'b1;
      cts_n_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      port_en_ff <= nxt_state == psw_pkg::ST_ACTIVE;
      // flow control taken from the value that lands with the state
      cts_n_ff <= !((nxt_state == psw_pkg::ST_ACTIVE) &&
                    (ctrl_ok ? wr_flow : flow_en_ff));
    end
  end

  assign cts_n = cts_n_ff;
  assign port_en = port_en_ff;
  assign mod_active = state_ff == psw_pkg::ST_ACTIVE;
  // characters only taken while the port is enabled; FIFO stalls the rest
  assign rx_ready = port_en_ff && fifo_in_ready;

  span_timer #(
    .W(psw_pkg::TMR_W)
  ) u_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  char_fifo #(
    .W(psw_pkg::CHAR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(rx_valid && port_en_ff),
    .in_ready(fifo_in_ready),
    .in_data(rx_data),
    .out_valid(fifo_out_valid),
    .out_ready(rxd_rd),
    .out_data(fifo_out_data)
  );

  // helper logic for checks
  logic [31:0] wake_cnt_ff;
  logic seen_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake_cnt_ff <= '0;
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= 1'b1;
      if (state_ff == psw_pkg::ST_WAKE) begin
        wake_cnt_ff <= wake_cnt_ff + 32'h0000_0001;
      end else begin
        wake_cnt_ff <= '0;
      end
    end
  end

  AST_WAKE_DTR: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_ff == psw_pkg::ST_WAKE && nxt_state == psw_pkg::ST_ACTIVE &&
     mode_ff == psw_pkg::PS_DTR && !ctrl_ok)
    |-> wake_cnt_ff == WAKE_CYCLES - 32'h0000_0001)
    else $error("dtr wake-up time wrong");

  AST_WAKE_RTS: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_ff == psw_pkg::ST_IDLE && mode_ff == psw_pkg::PS_RTS &&
     !rts_n && !ctrl_ok)
    |=> state_ff == psw_pkg::ST_WAKE && !port_en_ff)
    else $error("rts wake did not start");

  AST_RX_TAKEN: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_ff == psw_pkg::ST_ACTIVE && fifo_in_ready) |-> rx_ready)
    else $error("active port refused a character");

  AST_PERIODIC_IDLE: assert property (@(posedge mclk) disable iff (!arst_n)
    (mode_ff == psw_pkg::PS_PERIODIC && state_ff == psw_pkg::ST_ACTIVE &&
     tmr_done && !rx_take && !ctrl_ok)
    |=> state_ff == psw_pkg::ST_IDLE ##1 !port_en_ff)
    else $error("periodic window did not close");

  AST_VER_REJECT: assert property (@(posedge mclk) disable iff (!arst_n)
    (ctrl_wr && wr_mode == psw_pkg::PS_DTR &&
     PRODUCT_VER == psw_pkg::VER_FIRST)
    |=> mode_ff == $past(mode_ff) && rej_ff)
    else $error("dtr setting taken on first version");

  AST_CTS: assert property (@(posedge mclk) disable iff (!arst_n)
    cts_n == !(port_en_ff && flow_en_ff))
    else $error("cts does not follow port and flow control");

  AST_FLOW_RESET: assert property (@(posedge mclk) disable iff (!arst_n)
    !seen_ff |-> flow_en_ff && mode_ff == psw_pkg::PS_OFF)
    else $error("flow control not on after reset");

  AST_DTR_ANY_FLOW: assert property (@(posedge mclk) disable iff (!arst_n)
    (ctrl_wr && wr_mode == psw_pkg::PS_DTR &&
     PRODUCT_VER != psw_pkg::VER_FIRST)
    |=> mode_ff == psw_pkg::PS_DTR && flow_en_ff == $past(wr_flow))
    else $error("dtr setting refused");

  AST_RTS_NO_FLOW: assert property (@(posedge mclk) disable iff (!arst_n)
    mode_ff == psw_pkg::PS_RTS |-> !flow_en_ff)
    else $error("rts setting with flow control on");

  AST_LINE_OFF: assert property (@(posedge mclk) disable iff (!arst_n)
    (mode_ff inside {psw_pkg::PS_RTS, psw_pkg::PS_DTR} && !line_on &&
     !ctrl_ok)
    |=> !port_en_ff && state_ff == psw_pkg::ST_IDLE)
    else $error("port left enabled after line off");

  AST_STATE_PORT: assert property (@(posedge mclk) disable iff (!arst_n)
    port_en_ff == (state_ff == psw_pkg::ST_ACTIVE))
    else $error("port flag disagrees with state");
endmodule

// [tb/dte_model.sv]
/*
  Far-side terminal model: RTS/DTR lines and a byte source.
  Assumes mclk domain, active-low lines, bytes queued by the bench.
*/
`timescale 1ns/1ps
module dte_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic flow_on,
  input wire logic rts_on,
  input wire logic dtr_on,
  input wire logic rx_ready,
  output logic rts_n,
  output logic dtr_n,
  output logic rx_valid,
  output logic [psw_pkg::CHAR_W-1:0] rx_data
);
  logic [psw_pkg::CHAR_W-1:0] q[$];
  // with flow control the line is parked at ON
  assign rts_n = flow_on ? 1'b0 : !rts_on;
  assign dtr_n = !dtr_on;
  task automatic push(input logic [psw_pkg::CHAR_W-1:0] c);
    q.push_back(c);
  endtask
  // a byte stays offered until taken: nothing lost while port is off
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_valid <= 1'b0;
      rx_data <= 8'hff;
    end else if (rx_valid && rx_ready) begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end else if (!rx_valid && q.size() > 0) begin
      rx_valid <= 1'b1;
      rx_data <= q.pop_front();
    end
  end
endmodule

// [tb/testbench.sv]
/*
  Self-checking bench of the power-save control block over APB.
  Assumes a short wake count and a second instance of the first version.
*/
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] WAKE = 32'h0000_0014;
  logic mclk, arst_n, psel, penable, pwrite;
  logic [psw_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, pslverr_old, err, err_old;
  logic cts_n, port_en, mod_active, rx_ready, rts_n, dtr_n, rx_valid;
  logic [7:0] rx_data;
  logic flow_on, rts_on, dtr_on;
  int fails, samples_checked;

  // depth and version left at their defaults
  uart_psave_ctrl #(.WAKE_CYCLES(WAKE)) u_dut (.mclk(mclk),
    .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rts_n(rts_n), .dtr_n(dtr_n), .cts_n(cts_n),
    .port_en(port_en), .mod_active(mod_active), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready));
  // first product version, shares the bus to compare refusals
  uart_psave_ctrl #(.WAKE_CYCLES(WAKE), .PRODUCT_VER(8'h01))
    u_old (.mclk(mclk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(pslverr_old),
    .rts_n(rts_n), .dtr_n(dtr_n), .cts_n(), .port_en(),
    .mod_active(), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready());
  dte_model u_dte (.mclk(mclk), .arst_n(arst_n), .flow_on(flow_on),
    .rts_on(rts_on), .dtr_on(dtr_on), .rx_ready(rx_ready),
    .rts_n(rts_n), .dtr_n(dtr_n), .rx_valid(rx_valid),
    .rx_data(rx_data));

  always #4 mclk = ~mclk;

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t bit %b exp %b", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wait_en(input logic v, input int lim);
    int n;
    n = 0;
    while (port_en !== v && n < lim) begin
      step(1);
      n++;
    end
  endtask
  // setup, then access held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait-state count assumed; only the watchdog ends this wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    err_old = pslverr_old;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic t_reset();
    rd(psw_pkg::REG_CTRL);
    chk_w(rdata, 32'h0000_0010);
    rd(psw_pkg::REG_STATUS);
    chk_w(rdata, 32'h0000_0013);
    rd(psw_pkg::REG_IDLE);
    chk_w(rdata, psw_pkg::IDLE_RST);
    rd(psw_pkg::REG_ACT);
    chk_w(rdata, psw_pkg::ACT_RST);
    chk_b(cts_n, 1'b0);
    rd(8'h40);
    chk_b(err, 1'b1);
  endtask
  task automatic t_rts();
    wr(psw_pkg::REG_CTRL, 32'h0000_0012);
    chk_b(err, 1'b1);
    rd(psw_pkg::REG_STATUS);
    chk_b(rdata[psw_pkg::STS_REJ_BIT], 1'b1);
    wr(psw_pkg::REG_STATUS, 32'h0000_0008);
    rd(psw_pkg::REG_STATUS);
    chk_b(rdata[psw_pkg::STS_REJ_BIT], 1'b0);
    wr(psw_pkg::REG_CTRL, 32'h0000_0002);
    chk_b(err, 1'b0);
    flow_on <= 1'b0;
    rts_on <= 1'b0;
    step(2);
    chk_b(port_en, 1'b0);
    chk_b(rx_ready, 1'b0);
    u_dte.push(8'ha5);
    @(posedge mclk);
    rts_on <= 1'b1;
    step(3);
    // mid wake-up: waking, port off, cts high, buffer empty
    rd(psw_pkg::REG_STATUS);
    chk_w(rdata, 32'h0000_0054);
    step(WAKE - 6);
    chk_b(port_en, 1'b0);
    chk_b(mod_active, 1'b0);
    wait_en(1'b1, 4);
    chk_b(port_en, 1'b1);
    chk_b(mod_active, 1'b1);
    step(3);
    rd(psw_pkg::REG_RXDATA);
    chk_w(rdata, 32'h0000_01a5);
  endtask
  task automatic t_dtr();
    wr(psw_pkg::REG_CTRL, 32'h0000_0003);
    chk_b(err, 1'b0);
    chk_b(err_old, 1'b1);
    step(2);
    chk_b(cts_n, 1'b1);
    flow_on <= 1'b1;
    wr(psw_pkg::REG_CTRL, 32'h0000_0013);
    chk_b(err, 1'b0);
    dtr_on <= 1'b0;
    step(2);
    chk_b(port_en, 1'b0);
    chk_b(cts_n, 1'b1);
    @(posedge mclk);
    dtr_on <= 1'b1;
    step(WAKE);
    chk_b(port_en, 1'b0);
    wait_en(1'b1, 4);
    chk_b(port_en, 1'b1);
    step(2);
    chk_b(cts_n, 1'b0);
  endtask
  task automatic t_periodic();
    wr(psw_pkg::REG_IDLE, 32'h0000_0008);
    wr(psw_pkg::REG_ACT, 32'h0000_0008);
    wr(psw_pkg::REG_CTRL, 32'h0000_0011);
    step(1);
    chk_b(port_en, 1'b0);
    u_dte.push(8'h3c);
    step(2);
    chk_b(rx_valid, 1'b1);
    wait_en(1'b1, 20);
    chk_b(port_en, 1'b1);
    step(3);
    rd(psw_pkg::REG_RXDATA);
    chk_w(rdata, 32'h0000_013c);
    wait_en(1'b0, 30);
    chk_b(port_en, 1'b0);
    wr(psw_pkg::REG_CTRL, 32'h0000_0010);
  endtask
  // 17 bytes: one stalls in the terminal while the buffer is full
  task automatic t_fifo();
    for (int i = 0; i < 17; i++) u_dte.push(8'(8'h40 + i));
    step(40);
    chk_b(rx_ready, 1'b0);
    rd(psw_pkg::REG_STATUS);
    chk_b(rdata[psw_pkg::STS_FULL_BIT], 1'b1);
    for (int i = 0; i < 17; i++) begin
      rd(psw_pkg::REG_RXDATA);
      chk_w(rdata, 32'h0000_0140 + 32'(i));
    end
    rd(psw_pkg::REG_RXDATA);
    chk_b(rdata[psw_pkg::RXD_VALID_BIT], 1'b0);
    rd(psw_pkg::REG_STATUS);
    chk_b(rdata[psw_pkg::STS_EMPTY_BIT], 1'b1);
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {flow_on, rts_on, dtr_on} = 3'h7;
    fails = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_rts();
    t_dtr();
    t_periodic();
    t_fifo();
    wrap_up();
  end
endmodule
